// ===== dv/lcd_frame_clock_and_drive_control_bench.sv
`timescale 1ns/1ps
module lcd_frame_clock_and_drive_control_bench;
    reg clk;
    reg rst_n;
    reg [1:0] regAddr;
    reg [7:0] regWrData;
    reg regWrEn;
    reg regRdEn;
    reg runExt;
    wire [7:0] regRdData;
    wire extClkIn;
    wire panelClkTick_q;
    wire panelClk_q;
    wire frameStart_q;
    wire driverOn_q;
    wire [3:0] contrastLevel_q;
    int miscompares = 0;
    int tests_run = 0;
    int n;
    lfc_ext_src u_ext (.clkOut(extClkIn), .run(runExt));
    lfc_frame_clock u_dut (
        .clk(clk),
        .rst_n(rst_n),
        .regAddr(regAddr),
        .regWrData(regWrData),
        .regWrEn(regWrEn),
        .regRdEn(regRdEn),
        .regRdData(regRdData),
        .extClkIn(extClkIn),
        .panelClkTick_q(panelClkTick_q),
        .panelClk_q(panelClk_q),
        .frameStart_q(frameStart_q),
        .driverOn_q(driverOn_q),
        .contrastLevel_q(contrastLevel_q)
    );
    task automatic chk(input string s, input [15:0] e, input [15:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(input [1:0] a, input [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
    endtask
    task automatic rd(input [1:0] a, input [7:0] e);
        @(posedge clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        @(negedge clk);
        chk("register", {8'h00, e}, {8'h00, regRdData});
    endtask
    // restart counters with new settings
    task automatic cfg(input [7:0] f, input [7:0] c);
        wr(2'h2, 8'h00);
        wr(2'h0, f);
        wr(2'h2, c);
    endtask
    // cycles between two pulses
    task automatic gap(input bit f);
        int k;
        n = -1;
        for (k = 0; k < 9000; k++) begin
            @(negedge clk);
            if (n >= 0)
                n++;
            if ((f ? frameStart_q : panelClkTick_q) === 1'b1) begin
                if (n > 0)
                    break;
                n = 0;
            end
        end
    endtask
    task automatic hi;
        int k;
        for (k = 0; k < 99 && panelClkTick_q !== 1'b1; k++)
            @(negedge clk);
        chk("panel clock", 16'h0001, {15'h0000, panelClk_q});
        gap(1'b0);
        gap(1'b0);
        for (k = 0; k < 99 && driverOn_q !== 1'b1; k++)
            @(negedge clk);
        for (k = 0; k < 99 && driverOn_q === 1'b1; k++)
            @(negedge clk);
        n = k;
    endtask
    task automatic t_regs;
        rd(2'h0, 8'h00);
        wr(2'h0, 8'hFF);
        wr(2'h1, 8'hFF);
        wr(2'h2, 8'hC8);
        wr(2'h3, 8'hFF);
        rd(2'h0, 8'h77);
        rd(2'h1, 8'hEF);
        rd(2'h2, 8'h00);
        rd(2'h3, 8'h00);
    endtask
    task automatic t_div;
        int j;
        for (j = 0; j < 8; j++) begin
            cfg({1'b0, j[2:0], 4'h0}, 8'h01);
            gap(1'b0);
            chk("tick gap", j ? 32 << j : 16, n[15:0]);
            cfg({5'h00, j[2:0]}, 8'h01);
            gap(1'b0);
            chk("tick gap", 16 * (j + 1), n[15:0]);
        end
    endtask
    task automatic t_frame;
        int j;
        for (j = 0; j < 4; j++) begin
            cfg(8'h00, {2'h0, j[1:0], 4'h1});
            gap(1'b1);
            chk("frame gap", j == 2 ? 96 : 128, n[15:0]);
        end
        cfg(8'h12, 8'h31);
        gap(1'b1);
        chk("frame gap", 1536, n[15:0]);
    endtask
    task automatic t_drive;
        int j;
        logic [7:0] cc [4] = '{8'hC0, 8'hE0, 8'h20, 8'h20};
        logic [7:0] ct [4] = '{8'h31, 8'h31, 8'h35, 8'h01};
        for (j = 0; j < 4; j++) begin
            wr(2'h1, cc[j]);
            cfg(8'h00, ct[j]);
            hi;
            chk("drive time", 8, n[15:0]);
        end
    endtask
    task automatic t_misc;
        gap(1'b1);
        wr(2'h1, 8'h0A);
        chk("contrast", 16'h0000, {12'h000, contrastLevel_q});
        gap(1'b1);
        chk("contrast", 16'h000A, {12'h000, contrastLevel_q});
        runExt <= 1'b1;
        cfg(8'h00, 8'h03);
        gap(1'b0);
        chk("ext tick gap", 56, (n == 55 || n == 57) ? 16'd56 : n[15:0]);
    endtask
    task automatic results;
        if (miscompares == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        rst_n = 1'b0;
        regAddr = 2'h0;
        regWrData = 8'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        runExt = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_div;
        t_frame;
        t_drive;
        t_misc;
        results;
    end
    initial begin
        #400000;
        miscompares++;
        results;
    end
endmodule

// ===== dv/lfc_ext_src.sv
`timescale 1ns/1ps
module lfc_ext_src #(
    parameter HALF = 7
) (
    // source clock and run control
    output reg clkOut,
    input wire run
);
    initial clkOut = 1'b0;
    always #HALF clkOut = run ? ~clkOut : 1'b0;
endmodule

// ===== dv/lfc_frame_clock_properties.sv
`timescale 1ns/1ps
module lfc_frame_clock_props (
    // watched ports
    input wire clk,
    input wire rst_n,
    input wire [1:0] regAddr,
    input wire regRdEn,
    input wire [7:0] regRdData,
    input wire panelClkTick_q,
    input wire frameStart_q,
    input wire [3:0] contrastLevel_q
);
    reg [2:0] lastRd_q;
    always @(posedge clk) lastRd_q <= {regRdEn, regAddr};
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    rd_idle_a: assert property (!lastRd_q[2] |-> regRdData == 8'h00)
        else $error("read data not idle");
    frr_rsv_a: assert property (lastRd_q == 3'h4 |-> (regRdData & 8'h88) == 8'h00)
        else $error("frame-rate reserved bits set");
    ccr_rsv_a: assert property (lastRd_q == 3'h5 |-> !regRdData[4])
        else $error("contrast reserved bit set");
    ctl_rsv_a: assert property (lastRd_q == 3'h6 |-> (regRdData & 8'hC8) == 8'h00)
        else $error("control reserved bits set");
    sts_rsv_a: assert property (lastRd_q == 3'h7 |-> regRdData[7:5] == 3'h0)
        else $error("status upper bits set");
    contrast_frame_a: assert property ($changed(contrastLevel_q) |-> $rose(frameStart_q))
        else $error("contrast changed off frame");
    tick_gap_a: assert property (panelClkTick_q |=> !panelClkTick_q [*8])
        else $error("panel ticks too close");
    frame_gap_a: assert property (frameStart_q |=> !frameStart_q [*8])
        else $error("frame pulses too close");
endmodule
bind lfc_frame_clock lfc_frame_clock_props u_props (
    .clk(clk),
    .rst_n(rst_n),
    .regAddr(regAddr),
    .regRdEn(regRdEn),
    .regRdData(regRdData),
    .panelClkTick_q(panelClkTick_q),
    .frameStart_q(frameStart_q),
    .contrastLevel_q(contrastLevel_q)
);

// ===== include/lfc_consts.vh
// Summary of operation
// - frame-rate bits 7 and 3 read zero
// - tap field selects prescaler divisor 16..4096
// - divide field gives extra factor D=code+1
// - prescaler output divided by D
// - frame lasts K*N*D source clock periods
// - drive-time field selects driver on-time
// - on-time capped at half panel period
// - static or blanked: on-time half period
// - drive-time field may be omitted
// - contrast register bit 4 reads zero
// - contrast code forwarded to analog generator
// - contrast code latched at frame start
// - clock-select picks system or external source
// - duty field sets K factor
`ifndef LFC_CONSTS_VH
`define LFC_CONSTS_VH
`define LFC_ADDR_FRR 2'h0
`define LFC_ADDR_CCR 2'h1
`define LFC_ADDR_CTL 2'h2
`define LFC_ADDR_STS 2'h3
`define LFC_FRR_MASK 8'h77
`define LFC_CCR_MASK 8'hEF
`define LFC_CTL_MASK 8'h37
`define LFC_FRR_RST 8'h00
`define LFC_CCR_RST 8'h00
`define LFC_CTL_RST 8'h00
`define LFC_CTL_EN 0
`define LFC_CTL_CS 1
`define LFC_CTL_BLANK 2
`define LFC_CLK_MHZ 250
`define LFC_K_QUARTER 4'h8
`define LFC_K_THIRD 4'h6
`define LFC_DUTY_THIRD 2'h2
`define LFC_DC_HALF 3'h7
`define LFC_DRIVE_US0 300
`define LFC_DRIVE_US1 70
`define LFC_DRIVE_US2 150
`define LFC_DRIVE_US3 450
`define LFC_DRIVE_US4 575
`define LFC_DRIVE_US5 850
`define LFC_DRIVE_US6 1150
`define LFC_CYC_MAX 262143
`endif

// ===== src/lfc_frame_clock.v
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "lfc_consts.vh"
module lfc_frame_clock #(
    parameter HAS_DRIVE_TIME = 1
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // register port
    input wire [1:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrEn,
    input wire regRdEn,
    output reg [7:0] regRdData,
    // external asynchronous source clock level
    input wire extClkIn,
    // panel timing outputs
    output reg panelClkTick_q,
    output reg panelClk_q,
    output reg frameStart_q,
    output reg driverOn_q,
    output reg [3:0] contrastLevel_q
);
    reg [7:0] frameRateCfg_q;
    reg [7:0] contrastCfg_q;
    reg [7:0] ctrl_q;
    reg extSync1_q;
    reg extSync2_q;
    reg extPrev_q;
    reg [11:0] preCnt_q;
    reg [2:0] divCnt_q;
    reg [3:0] kCnt_q;
    reg [17:0] halfCnt_q;
    reg [17:0] halfLen_q;
    reg [17:0] driveCnt_q;
    reg [17:0] driveLen;
    reg [11:0] tapTop;
    reg [3:0] kTop;
    wire srcTick;
    wire preWrap;
    wire divWrap;
    wire frameEnd;
    wire enable;
    wire [7:0] ccrMask;

    // saturates: the longest nominal time overflows 18 bits, the half-period cap covers it
    function [17:0] usToCycles;
        input integer us;
        integer cyc;
        begin
            cyc = us * `LFC_CLK_MHZ;
            if (cyc > `LFC_CYC_MAX) begin
                usToCycles = 18'h3FFFF;
            end else begin
                usToCycles = cyc[17:0];
            end
        end
    endfunction

    // last panel tick of a frame
    function lastTick;
        input [3:0] cnt;
        input [3:0] top;
        begin
            lastTick = (cnt >= top);
        end
    endfunction

    assign enable = ctrl_q[`LFC_CTL_EN];
    assign ccrMask = HAS_DRIVE_TIME ? `LFC_CCR_MASK : 8'h0F;

    assign srcTick = ctrl_q[`LFC_CTL_CS] ? (extSync2_q & ~extPrev_q) : 1'b1;

    always @* begin
        case (frameRateCfg_q[6:4])
            3'h0: tapTop = 12'h00F;
            3'h1: tapTop = 12'h03F;
            3'h2: tapTop = 12'h07F;
            3'h3: tapTop = 12'h0FF;
            3'h4: tapTop = 12'h1FF;
            3'h5: tapTop = 12'h3FF;
            3'h6: tapTop = 12'h7FF;
            default: tapTop = 12'hFFF;
        endcase
    end

    always @* begin
        if (ctrl_q[5:4] == `LFC_DUTY_THIRD) begin
            kTop = `LFC_K_THIRD - 4'h1;
        end else begin
            kTop = `LFC_K_QUARTER - 4'h1;
        end
    end

    always @* begin
        case (contrastCfg_q[7:5])
            3'h0: driveLen = usToCycles(`LFC_DRIVE_US0);
            3'h1: driveLen = usToCycles(`LFC_DRIVE_US1);
            3'h2: driveLen = usToCycles(`LFC_DRIVE_US2);
            3'h3: driveLen = usToCycles(`LFC_DRIVE_US3);
            3'h4: driveLen = usToCycles(`LFC_DRIVE_US4);
            3'h5: driveLen = usToCycles(`LFC_DRIVE_US5);
            3'h6: driveLen = usToCycles(`LFC_DRIVE_US6);
            default: driveLen = halfLen_q;
        endcase
        if (ctrl_q[5:4] == 2'h0 || ctrl_q[`LFC_CTL_BLANK] || HAS_DRIVE_TIME == 0) begin
            driveLen = halfLen_q;
        end
        if (driveLen > halfLen_q) begin
            driveLen = halfLen_q;
        end
    end

    assign preWrap = srcTick && (preCnt_q == tapTop);
    // extra divide by code plus one
    assign divWrap = preWrap && (divCnt_q == frameRateCfg_q[2:0]);
    assign frameEnd = divWrap && lastTick(kCnt_q, kTop);

    // register writes
    always @(posedge clk) begin
        if (!rst_n) begin
            frameRateCfg_q <= `LFC_FRR_RST;
            contrastCfg_q <= `LFC_CCR_RST;
            ctrl_q <= `LFC_CTL_RST;
        end else if (regWrEn) begin
            case (regAddr)
                `LFC_ADDR_FRR: frameRateCfg_q <= regWrData & `LFC_FRR_MASK;
                `LFC_ADDR_CCR: contrastCfg_q <= regWrData & ccrMask;
                `LFC_ADDR_CTL: ctrl_q <= regWrData & `LFC_CTL_MASK;
                default: ctrl_q <= ctrl_q;
            endcase
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            regRdData <= 8'h00;
        end else if (regRdEn) begin
            case (regAddr)
                `LFC_ADDR_FRR: regRdData <= frameRateCfg_q;
                `LFC_ADDR_CCR: regRdData <= contrastCfg_q;
                `LFC_ADDR_CTL: regRdData <= ctrl_q;
                default: regRdData <= {3'h0, driverOn_q, contrastLevel_q};
            endcase
        end else begin
            regRdData <= 8'h00;
        end
    end

    // external clock synchroniser
    always @(posedge clk) begin
        if (!rst_n) begin
            extSync1_q <= 1'b0;
            extSync2_q <= 1'b0;
            extPrev_q <= 1'b0;
        end else begin
            extSync1_q <= extClkIn;
            extSync2_q <= extSync1_q;
            extPrev_q <= extSync2_q;
        end
    end

    // prescaler, divider and frame counters
    always @(posedge clk) begin
        if (!rst_n || !enable) begin
            preCnt_q <= 12'h000;
            divCnt_q <= 3'h0;
            kCnt_q <= 4'h0;
            panelClkTick_q <= 1'b0;
            panelClk_q <= 1'b0;
            frameStart_q <= 1'b0;
        end else begin
            panelClkTick_q <= divWrap;
            frameStart_q <= 1'b0;
            if (srcTick) begin
                preCnt_q <= preWrap ? 12'h000 : preCnt_q + 12'h001;
            end
            // panel clock from prescaler divided by D
            if (preWrap) begin
                divCnt_q <= divWrap ? 3'h0 : divCnt_q + 3'h1;
            end
            if (divWrap) begin
                panelClk_q <= ~panelClk_q;
                if (lastTick(kCnt_q, kTop)) begin
                    kCnt_q <= 4'h0;
                    frameStart_q <= 1'b1;
                end else begin
                    kCnt_q <= kCnt_q + 4'h1;
                end
            end
        end
    end

    // panel period measure and driver on-time
    always @(posedge clk) begin
        if (!rst_n || !enable) begin
            halfCnt_q <= 18'h00000;
            halfLen_q <= 18'h00001;
            driveCnt_q <= 18'h00000;
            driverOn_q <= 1'b0;
        end else begin
            if (divWrap) begin
                halfLen_q <= {1'b0, halfCnt_q[17:1]} + 18'h00001;
                halfCnt_q <= 18'h00000;
                driveCnt_q <= 18'h00001;
                driverOn_q <= 1'b1;
            end else begin
                if (halfCnt_q != 18'h3FFFF) begin
                    halfCnt_q <= halfCnt_q + 18'h00001;
                end
                if (driverOn_q) begin
                    if (driveCnt_q >= driveLen) begin
                        driverOn_q <= 1'b0;
                    end else begin
                        driveCnt_q <= driveCnt_q + 18'h00001;
                    end
                end
            end
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            contrastLevel_q <= 4'h0;
        end else if (frameEnd) begin
            contrastLevel_q <= contrastCfg_q[3:0];
        end
    end
endmodule
